//--- hdl/servo_off_brake_defines.vh
// constants for the servo-off brake sequencer and its register map
// assumes a 100 MHz system clock and a 32-bit APB register bus
`ifndef SERVO_OFF_BRAKE_DEFINES_VH
`define SERVO_OFF_BRAKE_DEFINES_VH

// register byte offsets
`define REG_SEQ_SET      12'h000
`define REG_STALL_DELAY  12'h004
`define REG_RUN_DELAY    12'h008
`define REG_REGEN_SEL    12'h00c
`define REG_IRQ_STATUS   12'h010
`define REG_IRQ_MASK     12'h014
`define REG_STATE        12'h018

// field limits and reset values
`define SEQ_MAX          4'h9
`define SEQ_RST          4'h0
`define DELAY_MAX        7'h64
`define DELAY_RST        7'h00
`define REGEN_MAX        2'h3
`define REGEN_RST_SMALL  2'h3
`define REGEN_RST_LARGE  2'h0
`define REGEN_BUILTIN    2'h0
`define REGEN_EXT_TRIP   2'h1
`define REGEN_EXT_NOTRIP 2'h2
`define REGEN_NONE       2'h3

// status / mask bit positions
`define IRQ_W            3
`define IRQ_STALL_DONE   0
`define IRQ_RUN_BRAKE    1
`define IRQ_REGEN_TRIP   2

// regen active field position in the selection register
`define REGEN_ACT_LSB    4

// timing
`define CLK_MHZ          100
`define TICK_MS          2
`define STALL_SPEED_RPM  16'h001e
`define REGEN_RATIO_PCT  10
`define PCT_FULL         100
`define REGEN_WINDOW     1000

`endif

//--- hdl/regen_ratio_monitor.v
// regenerative circuit active-ratio monitor
// assumes i_active is a same-clock level; i_clear is a level, held high to keep the window cleared
`timescale 1ns/10ps
`default_nettype none
`include "servo_off_brake_defines.vh"

module regen_ratio_monitor #(
  parameter WINDOW_CYCLES = `REGEN_WINDOW
) (
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  input  wire        i_clear,
  input  wire        i_active,
  output reg         o_over
);

  localparam integer WIN_LAST_I = WINDOW_CYCLES - 1;
  localparam integer LIMIT_I    = WINDOW_CYCLES * `REGEN_RATIO_PCT / `PCT_FULL;
  localparam [15:0]  WIN_LAST   = WIN_LAST_I[15:0];
  localparam [15:0]  LIMIT      = LIMIT_I[15:0];

  reg [15:0] win_cnt_q;
  reg [15:0] act_cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // window of fixed length; active cycles counted inside it
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      win_cnt_q <= 16'h0000;
      act_cnt_q <= 16'h0000;
      o_over    <= 1'b0;
    end else if (i_clear) begin
      win_cnt_q <= 16'h0000;
      act_cnt_q <= 16'h0000;
      o_over    <= 1'b0;
    end else if (win_cnt_q == WIN_LAST) begin
      win_cnt_q <= 16'h0000;
      act_cnt_q <= 16'h0000;
      o_over    <= (act_cnt_q + {15'h0000, i_active}) > LIMIT;
    end else begin
      win_cnt_q <= win_cnt_q + 16'h0001;
      act_cnt_q <= act_cnt_q + {15'h0000, i_active};
      o_over    <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- hdl/servo_off_brake_sequencer.v
// servo-off brake sequencer with regen resistor handling, APB registers
// assumes servo-on comes from a pin; speed and regen demand on i_clk_sys
`timescale 1ns/10ps
`default_nettype none
`include "servo_off_brake_defines.vh"

module servo_off_brake_sequencer #(
  parameter TICK_CYCLES  = `TICK_MS * 1000 * `CLK_MHZ,
  parameter SMALL_FRAME  = 1,
  parameter REGEN_WINDOW = `REGEN_WINDOW
) (
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  input  wire        i_servo_on_input,
  input  wire [15:0] i_motor_speed,
  input  wire        i_regen_request,
  input  wire        i_ctrl_power_up,
  output reg         o_brake_release_output,
  output reg         o_motor_energise,
  output reg         o_regen_switch,
  output reg         o_regen_overload_trip,
  output reg  [3:0]  o_servo_off_sequence,
  output reg         o_irq
);

  localparam [1:0] ST_OFF  = 2'b00;
  localparam [1:0] ST_ON   = 2'b01;
  localparam [1:0] ST_STALL = 2'b10;
  localparam [1:0] ST_RUN  = 2'b11;

  localparam integer TICK_LAST_I = TICK_CYCLES - 1;
  localparam [17:0]  TICK_LAST   = TICK_LAST_I[17:0];
  localparam [1:0]  REGEN_RST = (SMALL_FRAME != 0) ? `REGEN_RST_SMALL :
                                                     `REGEN_RST_LARGE;

  function sel_match;
    input [11:0] addr;
    input [11:0] offs;
    begin
      sel_match = (addr == offs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // servo-on pin synchroniser, change taken when stages 2 and 3 agree
  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg servo_on_q;

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q       <= 1'b0;
      s2_q       <= 1'b0;
      s3_q       <= 1'b0;
      servo_on_q <= 1'b0;
    end else begin
      s1_q <= i_servo_on_input;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        servo_on_q <= s3_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg [3:0]            seq_set_q;
  reg [6:0]            stall_delay_q;
  reg [6:0]            run_delay_q;
  reg [1:0]            regen_pend_q;
  reg [1:0]            regen_act_q;
  reg [`IRQ_W-1:0]     status_q;
  reg [`IRQ_W-1:0]     mask_q;
  reg [`IRQ_W-1:0]     irq_set;
  reg [1:0]            state_q;

  wire access  = i_psel & i_penable;
  wire done    = access & o_pready;
  wire wr_done = done & i_pwrite;
  wire rd_stat = done & ~i_pwrite & sel_match(i_paddr, `REG_IRQ_STATUS);

  wire a_seq   = sel_match(i_paddr, `REG_SEQ_SET);
  wire a_stall = sel_match(i_paddr, `REG_STALL_DELAY);
  wire a_run   = sel_match(i_paddr, `REG_RUN_DELAY);
  wire a_regen = sel_match(i_paddr, `REG_REGEN_SEL);
  wire a_stat  = sel_match(i_paddr, `REG_IRQ_STATUS);
  wire a_mask  = sel_match(i_paddr, `REG_IRQ_MASK);
  wire a_state = sel_match(i_paddr, `REG_STATE);
  wire a_any   = a_seq | a_stall | a_run | a_regen | a_stat | a_mask |
                 a_state;

  // out-of-range sequence, delay and regen values are refused and flagged
  reg bad_val;
  always @* begin
    bad_val = 1'b0;
    if (i_pwrite) begin
      if (a_seq && (i_pwdata[3:0] > `SEQ_MAX || |i_pwdata[31:4])) begin
        bad_val = 1'b1;
      end
      if ((a_stall || a_run) &&
          (i_pwdata[6:0] > `DELAY_MAX || |i_pwdata[31:7])) begin
        bad_val = 1'b1;
      end
      if (a_regen && |i_pwdata[31:2]) begin
        bad_val = 1'b1;
      end
      if (a_state) begin
        bad_val = 1'b1;
      end
    end
  end

  wire wr_ok = wr_done & ~bad_val & a_any;
  reg [31:0] rdata;
  always @* begin
    rdata = 32'h0000_0000;
    case (1'b1)
      a_seq:   rdata[3:0] = seq_set_q;
      a_stall: rdata[6:0] = stall_delay_q;
      a_run:   rdata[6:0] = run_delay_q;
      a_regen: begin
        rdata[1:0] = regen_pend_q;
        rdata[`REGEN_ACT_LSB+1:`REGEN_ACT_LSB] = regen_act_q;
      end
      a_stat:  rdata[`IRQ_W-1:0] = status_q;
      a_mask:  rdata[`IRQ_W-1:0] = mask_q;
      a_state: rdata[6:0] = {o_regen_overload_trip, o_regen_switch,
                             servo_on_q, o_motor_energise,
                             o_brake_release_output, state_q};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= access & ~o_pready;
      if (access && !o_pready) begin
        o_prdata  <= i_pwrite ? 32'h0000_0000 : rdata;
        o_pslverr <= ~a_any | bad_val;
      end else if (done) begin
        o_pslverr <= 1'b0;
      end
    end
  end

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seq_set_q     <= `SEQ_RST;
      stall_delay_q <= `DELAY_RST;
      run_delay_q   <= `DELAY_RST;
      regen_pend_q  <= REGEN_RST;
      mask_q        <= {`IRQ_W{1'b0}};
    end else if (wr_ok) begin
      if (a_seq) begin
        seq_set_q <= i_pwdata[3:0];
      end
      if (a_stall) begin
        stall_delay_q <= i_pwdata[6:0];
      end
      if (a_run) begin
        run_delay_q <= i_pwdata[6:0];
      end
      if (a_regen) begin
        regen_pend_q <= i_pwdata[1:0];
      end
      if (a_mask) begin
        mask_q <= i_pwdata[`IRQ_W-1:0];
      end
    end
  end

  // pending selection copied to the live one only at control power-up
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      regen_act_q <= REGEN_RST;
    end else if (i_ctrl_power_up) begin
      regen_act_q <= regen_pend_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 2 ms tick divider, restarted at the start of every delay
  reg  [17:0] tick_cnt_q;
  reg  [6:0]  delay_cnt_q;
  reg         restart;
  wire        tick = (tick_cnt_q == TICK_LAST);

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_q <= 18'h00000;
    end else if (restart || tick) begin
      tick_cnt_q <= 18'h00000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 18'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // regen processing and overload protection
  wire regen_over;
  wire regen_en   = (regen_act_q != `REGEN_NONE);
  wire trip_en    = (regen_act_q == `REGEN_EXT_TRIP) ||
                    (regen_act_q == `REGEN_BUILTIN);
  wire regen_on   = i_regen_request & regen_en;

  regen_ratio_monitor #(
    .WINDOW_CYCLES (REGEN_WINDOW)
  ) u_ratio (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_clear   (i_ctrl_power_up | ~trip_en),
    .i_active  (regen_on),
    .o_over    (regen_over)
  );

  wire trip_now = regen_over & trip_en;

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_regen_switch        <= 1'b0;
      o_regen_overload_trip <= 1'b0;
    end else begin
      o_regen_switch <= regen_on & ~o_regen_overload_trip;
      if (i_ctrl_power_up) begin
        o_regen_overload_trip <= 1'b0;
      end else if (trip_now) begin
        o_regen_overload_trip <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // servo on/off sequencing
  wire stalled = (i_motor_speed < `STALL_SPEED_RPM);
  reg  [1:0] state_d;
  reg        brake_d;
  reg        energise_d;

  always @* begin
    state_d    = state_q;
    brake_d    = o_brake_release_output;
    energise_d = o_motor_energise;
    restart    = 1'b0;
    irq_set    = {`IRQ_W{1'b0}};
    case (state_q)
      ST_OFF: begin
        brake_d    = 1'b0;
        energise_d = 1'b0;
        if (servo_on_q && !o_regen_overload_trip) begin
          state_d    = ST_ON;
          brake_d    = 1'b1;
          energise_d = 1'b1;
        end
      end
      ST_ON: begin
        if (!servo_on_q) begin
          restart = 1'b1;
          if (stalled) begin
            state_d = ST_STALL;
            brake_d = 1'b0;
            if (stall_delay_q == `DELAY_RST) begin
              state_d    = ST_OFF;
              energise_d = 1'b0;
              irq_set[`IRQ_STALL_DONE] = 1'b1;
            end
          end else begin
            state_d    = ST_RUN;
            energise_d = 1'b0;
            if (run_delay_q == `DELAY_RST) begin
              state_d = ST_OFF;
              brake_d = 1'b0;
              irq_set[`IRQ_RUN_BRAKE] = 1'b1;
            end
          end
        end
      end
      ST_STALL: begin
        if (tick && (delay_cnt_q + 7'h01 >= stall_delay_q)) begin
          state_d    = ST_OFF;
          energise_d = 1'b0;
          irq_set[`IRQ_STALL_DONE] = 1'b1;
        end
      end
      ST_RUN: begin
        if (stalled ||
            (tick && (delay_cnt_q + 7'h01 >= run_delay_q))) begin
          state_d = ST_OFF;
          brake_d = 1'b0;
          irq_set[`IRQ_RUN_BRAKE] = 1'b1;
        end
      end
      default: begin
        state_d    = ST_OFF;
        brake_d    = 1'b0;
        energise_d = 1'b0;
      end
    endcase
    if (o_regen_overload_trip) begin
      state_d    = ST_OFF;
      brake_d    = 1'b0;
      energise_d = 1'b0;
    end
    irq_set[`IRQ_REGEN_TRIP] = trip_now & ~o_regen_overload_trip;
  end

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q                <= ST_OFF;
      delay_cnt_q            <= 7'h00;
      o_brake_release_output <= 1'b0;
      o_motor_energise       <= 1'b0;
      o_servo_off_sequence   <= `SEQ_RST;
    end else begin
      state_q                <= state_d;
      o_brake_release_output <= brake_d;
      o_motor_energise       <= energise_d;
      o_servo_off_sequence   <= seq_set_q;
      if (restart) begin
        delay_cnt_q <= 7'h00;
      end else if (tick) begin
        delay_cnt_q <= delay_cnt_q + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, cleared by read; a new event wins over the clear
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_q <= {`IRQ_W{1'b0}};
      o_irq    <= 1'b0;
    end else begin
      status_q <= (rd_stat ? {`IRQ_W{1'b0}} : status_q) | irq_set;
      o_irq    <= |(((rd_stat ? {`IRQ_W{1'b0}} : status_q) | irq_set) &
                    mask_q);
    end
  end

endmodule
`default_nettype wire

//--- test/servo_off_brake_monitor.sv
// port assertions for the servo-off brake sequencer
// assumes the bench instance: 10-cycle tick, delays up to 100 ticks
`timescale 1ns/10ps
`default_nettype none
module servo_off_brake_monitor (
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_ctrl_power_up,
  input wire logic        i_regen_request,
  input wire logic [15:0] i_motor_speed,
  input wire logic        o_pready,
  input wire logic        o_brake_release_output,
  input wire logic        o_motor_energise,
  input wire logic        o_regen_switch,
  input wire logic        o_regen_overload_trip,
  input wire logic [3:0]  o_servo_off_sequence
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence stall_start;
    $fell(o_brake_release_output) && o_motor_energise;
  endsequence
  sequence run_start;
    $fell(o_motor_energise) && o_brake_release_output;
  endsequence
  a_seq_range: assert property (o_servo_off_sequence <= 4'h9)
    else $error("sequence setting out of range");
  a_stall_deenergise: assert property (
    stall_start |-> ##[1:1000] !o_motor_energise)
    else $error("stall de-energise late");
  a_release_energised: assert property (
    $rose(o_brake_release_output) |-> o_motor_energise)
    else $error("brake released while de-energised");
  a_run_brake: assert property (run_start |-> ##[1:1000]
    !o_brake_release_output) else $error("running brake late");
  a_slow_brake: assert property (o_brake_release_output &&
    !o_motor_energise && i_motor_speed < 16'h001e |-> ##[1:3]
    !o_brake_release_output) else $error("slow speed brake late");
  a_trip_sticky: assert property (
    o_regen_overload_trip && !i_ctrl_power_up |=> o_regen_overload_trip)
    else $error("trip lost");
  a_trip_off: assert property (o_regen_overload_trip[*3] |->
    !o_motor_energise && !o_brake_release_output)
    else $error("trip left motor on");
  a_switch_cause: assert property (
    o_regen_switch |-> $past(i_regen_request))
    else $error("regen switch without request");
  a_trip_clear: assert property (
    i_ctrl_power_up |=> !o_regen_overload_trip)
    else $error("trip not cleared");
  a_pready_wait: assert property (i_psel && !i_penable |=>
    !o_pready ##1 o_pready) else $error("bus wait state wrong");
endmodule
bind servo_off_brake_sequencer servo_off_brake_monitor mon_u (
  .i_clk_sys, .i_rst_n, .i_psel, .i_penable, .i_ctrl_power_up,
  .i_regen_request, .i_motor_speed, .o_pready, .o_brake_release_output,
  .o_motor_energise, .o_regen_switch, .o_regen_overload_trip,
  .o_servo_off_sequence);
`default_nettype wire

//--- test/host_ctrl_model.sv
// host controller model: servo-on pin and motor speed feed
// assumes commands from the bench on the system clock
`timescale 1ns/10ps
`default_nettype none
module host_ctrl_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_on_cmd,
  input  wire logic        i_load,
  input  wire logic        i_decel,
  input  wire logic [15:0] i_speed_set,
  output logic             o_servo_on_input,
  output logic [15:0]      o_motor_speed
);
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_servo_on_input <= 1'b0;
      o_motor_speed    <= 16'h0000;
    end else begin
      o_servo_on_input <= i_on_cmd;
      if (i_load)
        o_motor_speed <= i_speed_set;
      else if (i_decel && o_motor_speed != 16'h0000)
        o_motor_speed <= o_motor_speed - 16'h0001;
    end
  end
endmodule
`default_nettype wire

//--- test/servo_off_brake_sequencer_test.sv
// self-checking bench for the servo-off brake sequencer
// assumes 10-cycle tick and 100-cycle regen window parameters
`timescale 1ns/10ps
`default_nettype none
module servo_off_brake_sequencer_test;
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        on_cmd, load, decel, req, pwr_up, servo_on, ee, w, e;
  logic        brake, energise, sw, trip, irq;
  logic [1:0]  act;
  logic [3:0]  seq;
  logic [11:0] paddr, a;
  logic [15:0] speed_set, speed;
  logic [31:0] pwdata, prdata, r, d;
  int          fails, checks_done, n;
  localparam logic [45:0] rows [13] = '{
    {1'h1, 12'h000, 32'h9, 1'h0}, {1'h0, 12'h000, 32'h9, 1'h0},
    {1'h1, 12'h000, 32'ha, 1'h1}, {1'h0, 12'h000, 32'h9, 1'h0},
    {1'h1, 12'h004, 32'h65, 1'h1}, {1'h1, 12'h004, 32'h3, 1'h0},
    {1'h0, 12'h004, 32'h3, 1'h0}, {1'h1, 12'h008, 32'h5, 1'h0},
    {1'h1, 12'h00c, 32'h1, 1'h0}, {1'h0, 12'h00c, 32'h31, 1'h0},
    {1'h0, 12'h01c, 32'h0, 1'h1}, {1'h1, 12'h018, 32'h0, 1'h1},
    {1'h1, 12'h014, 32'h7, 1'h0}};
  servo_off_brake_sequencer #(.TICK_CYCLES(10), .SMALL_FRAME(1),
    .REGEN_WINDOW(100)) dut_u (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_servo_on_input(servo_on),
    .i_motor_speed(speed), .i_regen_request(req),
    .i_ctrl_power_up(pwr_up), .o_brake_release_output(brake),
    .o_motor_energise(energise), .o_regen_switch(sw),
    .o_regen_overload_trip(trip), .o_servo_off_sequence(seq),
    .o_irq(irq));
  host_ctrl_model host_u (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
    .i_on_cmd(on_cmd), .i_load(load), .i_decel(decel),
    .i_speed_set(speed_set), .o_servo_on_input(servo_on),
    .o_motor_speed(speed));
  //////////////////////////////////////////////////////////////////////
  task conclude;
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
           output logic [31:0] rd, output logic er);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= ad; pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fails++;
      conclude;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wt(input logic en, input logic lvl, output int c);
    c = 0;
    while ((en ? energise : brake) !== lvl && c < 2000) begin
      @(posedge clk_sys);
      c++;
    end
    if (c >= 2000) begin
      fails++;
      conclude;
    end
  endtask
  task pup;
    @(posedge clk_sys);
    pwr_up <= 1'b1;
    @(posedge clk_sys);
    pwr_up <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    conclude;
  end
  initial begin
    {psel, penable, pwrite, on_cmd, load, decel, req, pwr_up} = '0;
    paddr = '0; pwdata = '0; speed_set = '0; rst_n = 1'b0;
    fails = 0; checks_done = 0; act = 2'h3;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk({28'h0, seq}, 32'h0);
    foreach (rows[i]) begin
      {w, a, d, e} = rows[i];
      apb(w, a, d, r, ee);
      if (!w) chk(r, d);
      chk({31'h0, ee}, {31'h0, e});
    end
    chk({28'h0, seq}, 32'h9);
    // stalled servo-off, stall delay 3 ticks
    @(posedge clk_sys); on_cmd <= 1'b1; wt(1, 1, n);
    @(posedge clk_sys); on_cmd <= 1'b0; wt(0, 0, n); wt(1, 0, n);
    chk({31'h0, n >= 30 && n <= 31}, 32'h1);
    @(posedge clk_sys); chk({31'h0, irq}, 32'h1);
    apb(0, 12'h010, 32'h0, r, ee); chk(r, 32'h1);
    repeat (2) @(posedge clk_sys); chk({31'h0, irq}, 32'h0);
    // running servo-off, running delay 5 ticks at full speed
    @(posedge clk_sys); speed_set <= 16'h03e8; load <= 1'b1; on_cmd <= 1'b1;
    @(posedge clk_sys); load <= 1'b0; wt(1, 1, n);
    @(posedge clk_sys); on_cmd <= 1'b0; wt(1, 0, n); wt(0, 0, n);
    chk({31'h0, n >= 50 && n <= 51}, 32'h1);
    // long running delay cut short by deceleration
    apb(1, 12'h008, 32'h64, r, ee);
    @(posedge clk_sys); on_cmd <= 1'b1; wt(1, 1, n);
    @(posedge clk_sys); on_cmd <= 1'b0; speed_set <= 16'h0028;
    load <= 1'b1; decel <= 1'b1;
    @(posedge clk_sys); load <= 1'b0; wt(1, 0, n); wt(0, 0, n);
    chk({31'h0, n < 20}, 32'h1);
    // every regen selection, each loaded by a power-up pulse
    // motor held on, so a trip has to drop it
    on_cmd <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      req <= 1'b0;
      apb(1, 12'h00c, s, r, ee);
      apb(0, 12'h00c, 32'h0, r, ee);
      chk({30'h0, r[5:4]}, {30'h0, act});
      pup;
      req <= 1'b1;
      act = s[1:0];
      repeat (5) @(posedge clk_sys);
      chk({31'h0, sw}, {31'h0, s != 3});
      repeat (250) @(posedge clk_sys);
      chk({31'h0, trip}, {31'h0, s < 2});
      chk({31'h0, energise}, {31'h0, s > 1});
    end
    // reset in mid-run: outputs and registers back to reset values
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    chk({23'h0, seq, brake, energise, sw, trip, irq}, 32'h0);
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    on_cmd <= 1'b0;
    apb(0, 12'h00c, 32'h0, r, ee);
    chk(r, 32'h33);
    apb(0, 12'h000, 32'h0, r, ee);
    chk(r, 32'h0);
    conclude;
  end
endmodule
`default_nettype wire
